// File: hw/gpio_sync.sv
// two-flop synchroniser for the gpio inputs
// assumes inputs asynchronous to i_clk; no glitch filtering
`timescale 1ns/100ps
module gpio_sync #(
  parameter int W = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [2*W-1:0] pipe_ff;
  logic [2*W-1:0] nxt_pipe;

  always_comb
  begin
    nxt_pipe = {pipe_ff[W-1:0], i_d};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      pipe_ff <= '0;
    else
      pipe_ff <= nxt_pipe;
  end

  assign o_q = pipe_ff[2*W-1:W];
endmodule

// File: hw/instr_mem.sv
// shared instruction memory, one write port, registered read
// read of the address being written returns the old word
`timescale 1ns/100ps
module instr_mem #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rdata_ff <= '0;
    else
      rdata_ff <= mem[i_raddr];
  end

  assign o_rdata = rdata_ff;
endmodule

// File: hw/io_sm_core.sv
// sequencer core: branch, stall and shift-in execution, with its register port
// assumes flags, fifo status and emit count come from logic on i_clk
//
// Contract
// RULE1 - instructions are 16 bits; each finishes in one cycle unless stalled
// RULE2 - top side_set_bit_count field bits are side-set, rest are delay cycles
// RULE3 - branch loads pc with its address when condition true, else no-op
// RULE4 - branch delay always applies, after condition and pc update
// RULE5 - branch condition codes always, x zero, x--, y zero, y--, x!=y, pin, emit
// RULE6 - branch address is absolute in the shared instruction memory
// RULE7 - pin condition tests gpio at branch_pin_select, taken when high
// RULE8 - emit condition compares emit count against refill_threshold
// RULE9 - decrementing conditions always decrement; taken if old value nonzero
// RULE10 - stall holds until condition met; delay starts afterwards
// RULE11 - polarity bit picks wait for one or zero; source 00 absolute gpio
// RULE12 - source 01 tests pin at capture_pin_base plus index, modulo 32
// RULE13 - source 11 tests branch_pin_base plus index 0-3; source 10 a flag
// RULE14 - stall on flag with polarity one clears that flag when met
// RULE15 - flag_index_mode 00 direct, 10 adds machine number modulo 4
// RULE16 - mode 01 lower-numbered block, mode 11 higher-numbered, both wrapping
// RULE17 - shift-in moves n bits in configured direction; count saturates at 32
// RULE18 - shift-in sources pins, x, y, zeroes, reserved, capture, emit
// RULE19 - bit count field 1 to 32, zero code means 32
// RULE20 - autopush at flush_threshold pushes same cycle, clears register and count
// RULE21 - autopush into a full fifo stalls until room
// RULE22 - shift-in takes low bits of source, keeps order in both directions
// RULE23 - delay and stall hold pc and fetch nothing new
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
module io_sm_core #(
  parameter int VERSION = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [31:0] i_gpio,
  input wire logic [1:0] i_machine_id,
  input wire logic [7:0] i_flag_local,
  input wire logic [7:0] i_flag_prev,
  input wire logic [7:0] i_flag_next,
  input wire logic [31:0] i_emit_shift_reg,
  input wire logic [5:0] i_emit_count,
  input wire logic i_rx_full,
  output sm_pkg::push_t o_push,
  output sm_pkg::flag_clr_t o_flag_clr,
  output logic [4:0] o_side_set,
  output logic [4:0] o_pc
);
  sm_pkg::sm_state_t st_ff;
  sm_pkg::sm_state_t nxt;
  logic [15:0] ins;
  logic [31:0] g;
  logic [2:0] op;
  logic [4:0] jaddr;
  logic run;
  logic take;
  logic commit;
  logic wbit;
  logic clr_due;
  logic push_due;
  logic [2:0] ss;
  logic [2:0] dbits;
  logic [4:0] dmask;
  logic [4:0] dly_v;
  logic [4:0] side_v;
  logic [4:0] pidx;
  logic [4:0] bidx;
  logic [1:0] fbank;
  logic [2:0] fidx;
  logic fbit;
  logic [63:0] rot;
  logic [31:0] src;
  logic [31:0] srcm;
  logic [31:0] nisr;
  logic [5:0] n;
  logic [6:0] csum;
  logic [5:0] ncnt;
  logic imem_we;

  // threshold field of zero stands for a full word
  function automatic logic [5:0] thresh(input logic [4:0] t);
    return (t == 5'h00) ? sm_pkg::FULL_CNT : {1'b0, t};
  endfunction

  function automatic logic [31:0] low_mask(input logic [5:0] w);
    logic [63:0] m;
    m = (64'h1 << w) - 64'h1;
    return m[31:0];
  endfunction

  gpio_sync #(.W(32)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(i_gpio),
    .o_q(g)
  );

  assign imem_we = i_wr && (i_addr == sm_pkg::ADDR_IMEM);

  // read address is the next pc so the fetched word is ready with no bubble
  instr_mem #(.AW(sm_pkg::PC_W), .DW(sm_pkg::INSN_W)) u_mem (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_we(imem_we),
    .i_waddr(i_wdata[sm_pkg::IMEM_ADDR +: 5]),
    .i_wdata(i_wdata[15:0]),
    .i_raddr(nxt.pc),
    .o_rdata(ins)
  );

  always_comb
  begin
    nxt = st_ff;
    nxt.push.v = 1'b0;
    nxt.clr.v = 1'b0;
    nxt.rdata = 32'h0;
    run = (st_ff.phase == sm_pkg::ST_RUN) && st_ff.cfg.en;
    // RULE1 opcode field decode
    op = ins[15:13];
    jaddr = ins[4:0];
    commit = 1'b0;
    // RULE2 delay and side-set split
    ss = (st_ff.cfg.ss_cnt > sm_pkg::SS_MAX) ? sm_pkg::SS_MAX : st_ff.cfg.ss_cnt;
    dbits = sm_pkg::SS_MAX - ss;
    dmask = (5'h1 << dbits) - 5'h1;
    dly_v = ins[12:8] & dmask;
    side_v = ins[12:8] >> dbits;
    // RULE5 branch condition select
    unique case (ins[7:5])
      sm_pkg::C_ALWAYS: take = 1'b1;
      sm_pkg::C_XZERO: take = (st_ff.x == 32'h0);
      // RULE9 taken on old value
      sm_pkg::C_XDEC: take = (st_ff.x != 32'h0);
      sm_pkg::C_YZERO: take = (st_ff.y == 32'h0);
      sm_pkg::C_YDEC: take = (st_ff.y != 32'h0);
      sm_pkg::C_XNEY: take = (st_ff.x != st_ff.y);
      // RULE7 single branch pin
      sm_pkg::C_PIN: take = g[st_ff.cfg.bsel];
      // RULE8 emit count against refill threshold
      sm_pkg::C_EMIT_REG_EMPTY_COND: take = (i_emit_count < thresh(st_ff.cfg.refill));
    endcase
    // RULE15 flag index decode
    fbank = sm_pkg::BANK_LOCAL;
    fidx = ins[2:0];
    if (ins[4:3] == sm_pkg::FM_REL)
      fidx = {ins[2], ins[1:0] + i_machine_id};
    // RULE16 neighbouring block flags
    if (VERSION >= 1 && ins[4:3] == sm_pkg::FM_PREV)
      fbank = sm_pkg::BANK_PREV;
    if (VERSION >= 1 && ins[4:3] == sm_pkg::FM_NEXT)
      fbank = sm_pkg::BANK_NEXT;
    fbit = i_flag_local[fidx];
    if (fbank == sm_pkg::BANK_PREV)
      fbit = i_flag_prev[fidx];
    if (fbank == sm_pkg::BANK_NEXT)
      fbit = i_flag_next[fidx];
    // RULE12 mapped pin wraps modulo 32
    pidx = st_ff.cfg.inbase + ins[4:0];
    // RULE13 branch pin plus small index
    bidx = st_ff.cfg.bbase + {3'h0, ins[1:0]};
    // RULE11 stall source select
    unique case (ins[6:5])
      sm_pkg::WS_GPIO: wbit = g[ins[4:0]];
      sm_pkg::WS_PIN: wbit = g[pidx];
      sm_pkg::WS_FLAG: wbit = fbit;
      sm_pkg::WS_BPIN: wbit = (VERSION >= 1) ? g[bidx] : g[ins[4:0]];
    endcase
    // RULE18 shift-in source select
    rot = {g, g} >> st_ff.cfg.inbase;
    case (ins[7:5])
      sm_pkg::IS_PINS: src = rot[31:0];
      sm_pkg::IS_X: src = st_ff.x;
      sm_pkg::IS_Y: src = st_ff.y;
      sm_pkg::IS_ISR: src = st_ff.capture_shift_reg;
      sm_pkg::IS_OSR: src = i_emit_shift_reg;
      default: src = 32'h0;
    endcase
    // RULE19 zero count is a full word
    n = (ins[4:0] == 5'h00) ? sm_pkg::FULL_CNT : {1'b0, ins[4:0]};
    // RULE22 open a gap then copy low source bits
    srcm = src & low_mask(n);
    if (st_ff.cfg.dir)
      nisr = (st_ff.capture_shift_reg >> n) | (srcm << (sm_pkg::FULL_CNT - n));
    else
      nisr = (st_ff.capture_shift_reg << n) | srcm;
    // RULE17 count saturates at a full word
    csum = {1'b0, st_ff.icnt} + {1'b0, n};
    ncnt = (csum > 7'h20) ? sm_pkg::FULL_CNT : csum[5:0];
    push_due = st_ff.cfg.apush && (ncnt >= thresh(st_ff.cfg.flush));
    if (i_wr)
    begin
      case (i_addr)
        sm_pkg::ADDR_CTRL:
        begin
          nxt.cfg.en = i_wdata[sm_pkg::CTRL_EN];
          nxt.cfg.apush = i_wdata[sm_pkg::CTRL_APUSH];
          nxt.cfg.dir = i_wdata[sm_pkg::CTRL_DIR];
        end
        sm_pkg::ADDR_PINCFG:
        begin
          nxt.cfg.ss_cnt = i_wdata[sm_pkg::PIN_SS +: 3];
          nxt.cfg.bsel = i_wdata[sm_pkg::PIN_BSEL +: 5];
          nxt.cfg.inbase = i_wdata[sm_pkg::PIN_INB +: 5];
          nxt.cfg.bbase = i_wdata[sm_pkg::PIN_BBASE +: 5];
        end
        sm_pkg::ADDR_SHIFTCFG:
        begin
          nxt.cfg.flush = i_wdata[sm_pkg::SH_FLUSH +: 5];
          nxt.cfg.refill = i_wdata[sm_pkg::SH_REFILL +: 5];
        end
        sm_pkg::ADDR_X: nxt.x = i_wdata;
        sm_pkg::ADDR_Y: nxt.y = i_wdata;
        default: ;
      endcase
    end
    // RULE23 delay countdown holds pc
    if (st_ff.phase == sm_pkg::ST_DELAY && st_ff.cfg.en)
    begin
      if (st_ff.dly == 5'h1)
        nxt.phase = sm_pkg::ST_RUN;
      else
        nxt.dly = st_ff.dly - 5'h1;
    end
    if (run)
    begin
      // side-set is driven even while the instruction stalls
      nxt.side = side_v;
      case (op)
        sm_pkg::OP_JMP:
        begin
          commit = 1'b1;
          // RULE9 unconditional decrement
          if (ins[7:5] == sm_pkg::C_XDEC)
            nxt.x = st_ff.x - 32'h1;
          if (ins[7:5] == sm_pkg::C_YDEC)
            nxt.y = st_ff.y - 32'h1;
          // RULE3 RULE6 absolute branch target
          nxt.pc = take ? jaddr : st_ff.pc + 5'h1;
        end
        sm_pkg::OP_WAIT:
        begin
          // RULE10 stall until polarity matches
          commit = (wbit == ins[7]);
          if (commit)
            nxt.pc = st_ff.pc + 5'h1;
        end
        sm_pkg::OP_IN:
        begin
          // RULE21 full fifo stalls the whole shift
          commit = !(push_due && i_rx_full);
          if (commit)
          begin
            nxt.pc = st_ff.pc + 5'h1;
            // RULE20 push and clear in the same cycle
            nxt.capture_shift_reg = push_due ? 32'h0 : nisr;
            nxt.icnt = push_due ? 6'h00 : ncnt;
            nxt.push.v = push_due;
            nxt.push.data = nisr;
          end
        end
        default:
        begin
          commit = 1'b1;
          nxt.pc = st_ff.pc + 5'h1;
        end
      endcase
      // RULE4 RULE10 delay only after completion
      if (commit && dly_v != 5'h00)
      begin
        nxt.phase = sm_pkg::ST_DELAY;
        nxt.dly = dly_v;
      end
    end
    // RULE14 clear the flag when the stall is met
    clr_due = run && commit && op == sm_pkg::OP_WAIT && ins[6:5] == sm_pkg::WS_FLAG && ins[7];
    if (clr_due)
    begin
      nxt.clr.v = 1'b1;
      nxt.clr.bank = fbank;
      nxt.clr.idx = fidx;
    end
    // disabling wins over any pending delay
    if (!nxt.cfg.en)
      nxt.phase = sm_pkg::ST_HALT;
    else if (st_ff.phase == sm_pkg::ST_HALT)
      nxt.phase = sm_pkg::ST_RUN;
    if (i_rd)
    begin
      case (i_addr)
        sm_pkg::ADDR_CTRL:
        begin
          nxt.rdata[sm_pkg::CTRL_EN] = st_ff.cfg.en;
          nxt.rdata[sm_pkg::CTRL_APUSH] = st_ff.cfg.apush;
          nxt.rdata[sm_pkg::CTRL_DIR] = st_ff.cfg.dir;
        end
        sm_pkg::ADDR_PINCFG:
        begin
          nxt.rdata[sm_pkg::PIN_SS +: 3] = st_ff.cfg.ss_cnt;
          nxt.rdata[sm_pkg::PIN_BSEL +: 5] = st_ff.cfg.bsel;
          nxt.rdata[sm_pkg::PIN_INB +: 5] = st_ff.cfg.inbase;
          nxt.rdata[sm_pkg::PIN_BBASE +: 5] = st_ff.cfg.bbase;
        end
        sm_pkg::ADDR_SHIFTCFG:
        begin
          nxt.rdata[sm_pkg::SH_FLUSH +: 5] = st_ff.cfg.flush;
          nxt.rdata[sm_pkg::SH_REFILL +: 5] = st_ff.cfg.refill;
        end
        sm_pkg::ADDR_STATUS:
        begin
          nxt.rdata[sm_pkg::STAT_PC +: 5] = st_ff.pc;
          nxt.rdata[sm_pkg::STAT_PHASE +: 3] = st_ff.phase;
          nxt.rdata[sm_pkg::STAT_CNT +: 6] = st_ff.icnt;
        end
        sm_pkg::ADDR_X: nxt.rdata = st_ff.x;
        sm_pkg::ADDR_Y: nxt.rdata = st_ff.y;
        sm_pkg::ADDR_ISR: nxt.rdata = st_ff.capture_shift_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st_ff <= sm_pkg::SM_RST;
    else
      st_ff <= nxt;
  end

  assign o_rdata = st_ff.rdata;
  assign o_push = st_ff.push;
  assign o_flag_clr = st_ff.clr;
  assign o_side_set = st_ff.side;
  assign o_pc = st_ff.pc;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_jmp_target: assert property (run && op == sm_pkg::OP_JMP && take // RULE3
    |=> st_ff.pc == $past(jaddr))
    else $error("branch target not loaded");
  a_jmp_fall: assert property (run && op == sm_pkg::OP_JMP && !take // RULE3
    |=> st_ff.pc == $past(st_ff.pc) + 5'h1)
    else $error("untaken branch did not advance");
  a_dec_x: assert property (run && op == sm_pkg::OP_JMP && ins[7:5] == sm_pkg::C_XDEC // RULE9
    |=> st_ff.x == $past(st_ff.x) - 32'h1)
    else $error("x not decremented");
  a_delay_len: assert property (commit && dly_v == 5'h3 && !i_wr // RULE4
    |=> st_ff.phase == sm_pkg::ST_DELAY [*3] ##1 st_ff.phase != sm_pkg::ST_DELAY)
    else $error("delay length wrong");
  a_delay_hold: assert property (st_ff.phase == sm_pkg::ST_DELAY // RULE23
    |=> st_ff.pc == $past(st_ff.pc) && !o_push.v)
    else $error("pc moved during delay");
  a_wait_stall: assert property (run && op == sm_pkg::OP_WAIT && !commit // RULE10
    |=> st_ff.pc == $past(st_ff.pc) && st_ff.phase != sm_pkg::ST_DELAY)
    else $error("stall did not hold");
  a_flag_clear: assert property (o_flag_clr.v |-> $past(clr_due)) // RULE14
    else $error("flag clear without met stall");
  a_push_zero: assert property (o_push.v |-> st_ff.capture_shift_reg == 32'h0 && st_ff.icnt == 6'h00) // RULE20
    else $error("push left capture register set");
  a_full_stall: assert property (run && op == sm_pkg::OP_IN && push_due && i_rx_full // RULE21
    |=> !o_push.v && st_ff.pc == $past(st_ff.pc) && st_ff.capture_shift_reg == $past(st_ff.capture_shift_reg))
    else $error("push into full fifo");
  a_cnt_sat: assert property (st_ff.icnt <= sm_pkg::FULL_CNT) // RULE17
    else $error("shift count above a word");

  c_jmp_taken: cover property (run && op == sm_pkg::OP_JMP && take);
  c_autopush: cover property (o_push.v);
  c_wait_met: cover property (run && op == sm_pkg::OP_WAIT && !commit ##1 commit);
  c_delay: cover property (commit && dly_v != 5'h00);
endmodule

// File: hw/sm_pkg.sv
// constants, field layout and state types of the branch, stall and shift-in sequencer
// assumes one 40 MHz system clock and a plain strobe register port
package sm_pkg;
  localparam int CLK_MHZ = 40;
  localparam int PC_W = 5;
  localparam int INSN_W = 16;
  localparam logic [2:0] SS_MAX = 3'h5;
  localparam logic [5:0] FULL_CNT = 6'h20;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PINCFG = 8'h04;
  localparam logic [7:0] ADDR_SHIFTCFG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_X = 8'h10;
  localparam logic [7:0] ADDR_Y = 8'h14;
  localparam logic [7:0] ADDR_ISR = 8'h18;
  localparam logic [7:0] ADDR_IMEM = 8'h1C;
  localparam int CTRL_EN = 0;
  localparam int CTRL_APUSH = 1;
  localparam int CTRL_DIR = 2;
  localparam int PIN_SS = 0;
  localparam int PIN_BSEL = 8;
  localparam int PIN_INB = 16;
  localparam int PIN_BBASE = 24;
  localparam int SH_FLUSH = 0;
  localparam int SH_REFILL = 8;
  localparam int STAT_PC = 0;
  localparam int STAT_PHASE = 8;
  localparam int STAT_CNT = 16;
  localparam int IMEM_ADDR = 16;
  localparam logic [2:0] OP_JMP = 3'h0;
  localparam logic [2:0] OP_WAIT = 3'h1;
  localparam logic [2:0] OP_IN = 3'h2;
  localparam logic [2:0] C_ALWAYS = 3'h0;
  localparam logic [2:0] C_XZERO = 3'h1;
  localparam logic [2:0] C_XDEC = 3'h2;
  localparam logic [2:0] C_YZERO = 3'h3;
  localparam logic [2:0] C_YDEC = 3'h4;
  localparam logic [2:0] C_XNEY = 3'h5;
  localparam logic [2:0] C_PIN = 3'h6;
  localparam logic [2:0] C_EMIT_REG_EMPTY_COND = 3'h7;
  localparam logic [1:0] WS_GPIO = 2'h0;
  localparam logic [1:0] WS_PIN = 2'h1;
  localparam logic [1:0] WS_FLAG = 2'h2;
  localparam logic [1:0] WS_BPIN = 2'h3;
  localparam logic [1:0] FM_DIRECT = 2'h0;
  localparam logic [1:0] FM_PREV = 2'h1;
  localparam logic [1:0] FM_REL = 2'h2;
  localparam logic [1:0] FM_NEXT = 2'h3;
  localparam logic [2:0] IS_PINS = 3'h0;
  localparam logic [2:0] IS_X = 3'h1;
  localparam logic [2:0] IS_Y = 3'h2;
  localparam logic [2:0] IS_ISR = 3'h6;
  localparam logic [2:0] IS_OSR = 3'h7;
  localparam logic [1:0] BANK_LOCAL = 2'h0;
  localparam logic [1:0] BANK_PREV = 2'h1;
  localparam logic [1:0] BANK_NEXT = 2'h2;
  typedef enum logic [2:0] {ST_HALT = 3'h1, ST_RUN = 3'h2, ST_DELAY = 3'h4} phase_t;
  typedef struct packed {
    logic en;
    logic apush;
    logic dir;
    logic [2:0] ss_cnt;
    logic [4:0] bsel;
    logic [4:0] inbase;
    logic [4:0] bbase;
    logic [4:0] flush;
    logic [4:0] refill;
  } cfg_t;
  typedef struct packed {
    logic v;
    logic [31:0] data;
  } push_t;
  typedef struct packed {
    logic v;
    logic [1:0] bank;
    logic [2:0] idx;
  } flag_clr_t;
  typedef struct packed {
    phase_t phase;
    cfg_t cfg;
    logic [4:0] pc;
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] capture_shift_reg;
    logic [5:0] icnt;
    logic [4:0] dly;
    logic [4:0] side;
    push_t push;
    flag_clr_t clr;
    logic [31:0] rdata;
  } sm_state_t;
  localparam sm_state_t SM_RST = '{phase: ST_HALT, default: '0};
endpackage

// File: tb/far_side_model.sv
// flag banks of this and the neighbour blocks, and a receive fifo stand-in
// assumes clear and push pulses arrive registered on i_clk
`timescale 1ns/100ps
module far_side_model #(
  parameter int DEPTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sm_pkg::push_t i_push,
  input wire sm_pkg::flag_clr_t i_clr,
  input wire logic i_set_v,
  input wire logic [1:0] i_set_bank,
  input wire logic [7:0] i_set_val,
  input wire logic i_pop,
  output logic [2:0][7:0] o_flag,
  output logic o_rx_full
);
  int level;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_flag <= '0;
      level <= 0;
    end
    else
    begin
      if (i_set_v)
        o_flag[i_set_bank] <= i_set_val;
      if (i_clr.v)
        o_flag[i_clr.bank][i_clr.idx] <= 1'b0;
      if (i_push.v && !i_pop)
        level <= level + 1;
      else if (i_pop && !i_push.v && level > 0)
        level <= level - 1;
    end
  end
  // full stays up until the bench drains
  assign o_rx_full = (level >= DEPTH);
endmodule

// File: tb/tb_top.sv
// self-checking bench for the branch, stall and shift-in sequencer
// assumes the far side model stands in for flag banks and the receive fifo
`timescale 1ns/100ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rd_pend = 1'b0;
  logic set_v = 1'b0;
  logic pop = 1'b0;
  logic rx_full;
  logic [1:0] set_bank = 2'h0;
  logic [7:0] set_val = 8'h00;
  logic [7:0] i_addr = 8'h00;
  logic [5:0] emit_cnt = 6'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] i_gpio = 32'h0;
  logic [31:0] emit = 32'h0;
  logic [31:0] seed = 32'h61;
  logic [31:0] o_rdata;
  logic [2:0][7:0] flag;
  logic [4:0] o_side_set;
  logic [4:0] o_pc;
  sm_pkg::push_t o_push;
  sm_pkg::flag_clr_t o_flag_clr;
  logic [31:0] rd_q[$];
  logic [31:0] push_q[$];
  logic [31:0] clr_q[$];
  // relative flag case wraps: index 3 plus machine 2 lands on flag 1
  logic [4:0] widx [7] = '{5'h11, 5'h03, 5'h02, 5'h13, 5'h0D, 5'h1E, 5'h02};
  logic [4:0] wtgt [7] = '{5'h11, 5'h01, 5'h01, 5'h01, 5'h05, 5'h06, 5'h02};
  logic [1:0] wsrc [7] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2};
  logic [1:0] wbnk [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
  logic [6:0] wpol = 7'h3D;
  int failures = 0;
  int checks = 0;

  always #12.5 i_clk = ~i_clk;

  // machine number tied: flag offsets below are worked out for machine 2
  io_sm_core DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio(i_gpio), .i_machine_id(2'h2), .i_flag_local(flag[0]),
    .i_flag_prev(flag[1]), .i_flag_next(flag[2]), .i_emit_shift_reg(emit), .i_emit_count(emit_cnt),
    .i_rx_full(rx_full), .o_push(o_push), .o_flag_clr(o_flag_clr), .o_side_set(o_side_set), .o_pc(o_pc));
  far_side_model FAR (.i_clk(i_clk), .i_rst(i_rst), .i_push(o_push), .i_clr(o_flag_clr), .i_set_v(set_v),
    .i_set_bank(set_bank), .i_set_val(set_val), .i_pop(pop), .o_flag(flag), .o_rx_full(rx_full));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic take(ref logic [31:0] q[$], input logic [31:0] got);
    if (q.size() == 0)
    begin
      failures++;
      $display("ERROR %0t unexpected result %h", $time, got);
    end
    else
      cmp(got, q.pop_front());
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // left keeps the gap at the bottom, right at the top; a count of 32 replaces all
  function automatic logic [31:0] shin(input logic [31:0] r, input logic [31:0] src, input int n, input int d);
    logic [31:0] m;
    m = (n == 32) ? 32'hFFFFFFFF : ((32'h1 << n) - 32'h1);
    src = src & m;
    if (n == 32)
      return src;
    return (d == 0) ? ((r << n) | src) : ((r >> n) | (src << (32 - n)));
  endfunction

  function automatic logic [15:0] jmp(input int c, input int a, input logic [4:0] f);
    return {3'h0, f, 3'(c), 5'(a)};
  endfunction

  function automatic logic [15:0] ins(input int src, input int n);
    return {3'h2, 5'h00, 3'(src), 5'(n)};
  endfunction

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic ld(input int a, input logic [15:0] w);
    bus(1'b1, sm_pkg::ADDR_IMEM, {11'h000, 5'(a), w});
  endtask

  task automatic setbank(input logic [1:0] b, input logic [7:0] v);
    @(posedge i_clk);
    set_v <= 1'b1;
    set_bank <= b;
    set_val <= v;
    @(posedge i_clk);
    set_v <= 1'b0;
  endtask

  task automatic restart(input logic [31:0] pincfg, input logic [31:0] shcfg);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    bus(1'b1, sm_pkg::ADDR_PINCFG, pincfg);
    bus(1'b1, sm_pkg::ADDR_SHIFTCFG, shcfg);
  endtask

  always @(posedge i_clk)
  begin
    rd_pend <= i_rd;
    if (rd_pend)
      take(rd_q, o_rdata);
    if (o_push.v === 1'b1)
      take(push_q, o_push.data);
    if (o_flag_clr.v === 1'b1)
      take(clr_q, {27'h0, o_flag_clr.bank, o_flag_clr.idx});
  end

  initial
  begin
    repeat (20000) @(posedge i_clk);
    failures++;
    $display("ERROR %0t run did not finish", $time);
    finish_test();
  end

  initial
  begin
    logic [31:0] x, y, g, v, s;
    logic [4:0] sel;
    logic pol;
    int n;
    restart(32'h0, 32'h0);
    rd(sm_pkg::ADDR_STATUS, 32'h100);
    rd(8'h40, 32'h0);
    bus(1'b1, sm_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    rd(sm_pkg::ADDR_STATUS, 32'h100);
    $display("test register port done");
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 8; c++)
      begin
        sel = 5'(xs());
        x = (p == 1) ? (xs() | 32'h1) : 32'h0;
        y = (p == 1) ? (x ^ 32'h2) : 32'h0;
        i_gpio <= (p == 1) ? (32'h1 << sel) : ~(32'h1 << sel);
        emit_cnt <= (p == 1) ? 6'h00 : 6'h20;
        restart({19'h0, sel, 8'h00}, 32'h0);
        bus(1'b1, sm_pkg::ADDR_X, x);
        bus(1'b1, sm_pkg::ADDR_Y, y);
        ld(0, jmp(c, 10, 5'h00));
        ld(1, jmp(0, 1, 5'h00));
        ld(10, jmp(0, 10, 5'h00));
        bus(1'b1, sm_pkg::ADDR_CTRL, 32'h1);
        repeat (4) @(posedge i_clk);
        n = (((p == 1) ? 8'hF5 : 8'h0B) >> c) & 1;
        rd(sm_pkg::ADDR_STATUS, (n == 1) ? 32'h20A : 32'h201);
        rd(sm_pkg::ADDR_X, (c == 2) ? x - 32'h1 : x);
        rd(sm_pkg::ADDR_Y, (c == 4) ? y - 32'h1 : y);
      end
    $display("test branch conditions done");
    // two side-set bits above three delay bits
    restart(32'h2, 32'h0);
    ld(0, jmp(0, 4, 5'h1B));
    ld(4, jmp(0, 4, 5'h10));
    bus(1'b1, sm_pkg::ADDR_CTRL, 32'h1);
    for (int k = 0; k < 5; k++)
    begin
      @(posedge i_clk);
      #1;
      cmp(32'(o_side_set), (k < 4) ? 32'h3 : 32'h2);
      cmp(32'(o_pc), 32'h4);
    end
    $display("test delay and side-set done");
    for (int e = 0; e < 7; e++)
    begin
      pol = wpol[e];
      i_gpio <= {32{pol}} ^ (32'h1 << wtgt[e]);
      restart(32'h1F1E0000, 32'h0);
      for (int b = 0; b < 3; b++)
        setbank(2'(b), {8{pol}} ^ ((b == wbnk[e] && wsrc[e] == 2'h2) ? (8'h1 << wtgt[e][2:0]) : 8'h00));
      ld(0, {3'h1, 5'h00, pol, wsrc[e], widx[e]});
      ld(1, jmp(0, 1, 5'h00));
      bus(1'b1, sm_pkg::ADDR_CTRL, 32'h1);
      repeat (4) @(posedge i_clk);
      rd(sm_pkg::ADDR_STATUS, 32'h200);
      if (wsrc[e] == 2'h2 && pol)
        clr_q.push_back({27'h0, wbnk[e], wtgt[e][2:0]});
      if (wsrc[e] == 2'h2)
        setbank(wbnk[e], {8{pol}});
      else
        i_gpio <= {32{pol}};
      repeat (4) @(posedge i_clk);
      rd(sm_pkg::ADDR_STATUS, 32'h201);
    end
    $display("test stall sources done");
    for (int d = 0; d < 2; d++)
    begin
      x = xs();
      y = xs();
      g = xs();
      v = xs();
      i_gpio <= g;
      emit <= v;
      restart(32'h001E0000, 32'h15);
      bus(1'b1, sm_pkg::ADDR_X, x);
      bus(1'b1, sm_pkg::ADDR_Y, y);
      ld(0, ins(1, 5));
      ld(1, ins(2, 3));
      ld(2, ins(3, 4));
      ld(3, ins(0, 2));
      ld(4, ins(7, 4));
      ld(5, ins(6, 3));
      ld(6, jmp(0, 6, 5'h00));
      s = shin(32'h0, x, 5, d);
      s = shin(s, y, 3, d);
      s = shin(s, 32'h0, 4, d);
      s = shin(s, (g >> 30) | (g << 2), 2, d);
      s = shin(s, v, 4, d);
      s = shin(s, s, 3, d);
      push_q.push_back(s);
      bus(1'b1, sm_pkg::ADDR_CTRL, (d == 1) ? 32'h7 : 32'h3);
      repeat (10) @(posedge i_clk);
      rd(8'h18, 32'h0);
      rd(sm_pkg::ADDR_STATUS, 32'h206);
    end
    $display("test shift-in done");
    // zero count means a whole word
    x = xs();
    y = xs();
    restart(32'h0, 32'h0);
    bus(1'b1, sm_pkg::ADDR_X, x);
    bus(1'b1, sm_pkg::ADDR_Y, y);
    ld(0, ins(1, 0));
    ld(1, ins(2, 3));
    ld(2, ins(2, 0));
    ld(3, jmp(0, 3, 5'h00));
    push_q.push_back(x);
    push_q.push_back(y);
    bus(1'b1, sm_pkg::ADDR_CTRL, 32'h3);
    repeat (8) @(posedge i_clk);
    rd(sm_pkg::ADDR_STATUS, 32'h30202);
    @(posedge i_clk);
    pop <= 1'b1;
    @(posedge i_clk);
    pop <= 1'b0;
    for (n = 0; n < 20 && o_pc !== 5'h03; n++)
      @(posedge i_clk);
    if (n == 20)
    begin
      failures++;
      $display("ERROR %0t stalled shift never resumed", $time);
    end
    rd(sm_pkg::ADDR_STATUS, 32'h203);
    rd(8'h18, 32'h0);
    repeat (4) @(posedge i_clk);
    $display("test full fifo done");
    if (rd_q.size() + push_q.size() + clr_q.size() != 0)
    begin
      failures++;
      $display("ERROR %0t expected results never seen", $time);
    end
    finish_test();
  end
endmodule
